// File: design/sfcfe_pkg.sv
// serial flash command front end: shared constants and types
// assumes a 10 MHz system clock and a link clock well below it
package sfcfe_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS   = 1000;
  localparam int POR_CYCLES    =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int OPC_BITS      = 8;
  localparam int ADDR_BITS     = 24;
  localparam int PAGE_BITS     = 12;
  localparam int STD_BYTE_BITS = 10;
  localparam int BIN_BYTE_BITS = 9;
  localparam int BIN_LIN_BITS  = 21;
  localparam int STD_PAGE_LSB  = 10;
  localparam int BIN_PAGE_LSB  = 9;

  localparam logic [4:0] OPC_CNT  = 5'h08;
  localparam logic [4:0] ADDR_CNT = 5'h18;
  localparam logic [4:0] BYTE_CNT = 5'h08;
  localparam logic [2:0] OUT_LAST = 3'h7;

  // pin sync reset values: cs_n, sck, si, wp_n, reset_n
  localparam logic [4:0] PIN_RST_VAL = 5'h13;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_REJ  = 6'h10,
    ST_HOLD = 6'h20
  } sfcfe_state_t;

endpackage

// File: design/sfcfe_por.sv
// internal power-on reset stretcher
// holds the core in reset for a fixed count after system reset
`timescale 1ns/10ps
`default_nettype none
module sfcfe_por #(
  parameter int CYC = 10
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      por_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (cnt != LAST)
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      por_o <= 1'b1;
    else
      por_o <= (cnt != LAST);
  end
endmodule
`default_nettype wire

// File: design/sfcfe_sync.sv
// two-stage synchroniser for a group of asynchronous pins
// assumes each bit is independent; no multi-bit coherence
`timescale 1ns/10ps
`default_nettype none
module sfcfe_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/sfcfe_top.sv
// serial flash command front end: pin sampling, framing, decode
// assumes link pins are asynchronous and sck is at most clk/4
//
// Notes on behaviour
// - input bits taken on serial clock rise
// - deselected device ignores serial input
// - output bit changes on serial clock fall
// - output high impedance while deselected
// - write protect guards marked sectors always; the code has no sector marks, it rejects non-exempt modify commands
// - write protect freezes protection register
// - protected program or erase is discarded
// - rejected command idles after deselect
// - protect and lockdown commands still accepted
// - floating write protect reads as deasserted; the code has no pull-up, wp_n reads high only while RST_I is high
// - reset pin low aborts and idles
// - held in reset while pin low
// - device makes its own power-on reset
// - select fall, then 8-bit opcode, address
// - all fields shifted most significant first
// - three address bytes, dummy bits leading
// - standard pages: 10-bit buffer byte
// - standard pages: 12 page, 10 byte
// - binary pages: 9-bit buffer byte
// - binary pages: 21-bit linear, 12/9 split
// - select fall starts, select rise ends
// - busy past select rise delays standby
`timescale 1ns/10ps
`default_nettype none
module sfcfe_top
  import sfcfe_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES
) (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     CS_N_I,
  input  wire logic                     SCK_I,
  input  wire logic                     SI_I,
  input  wire logic                     WP_N_I,
  input  wire logic                     RESET_N_I,
  output logic                          SO_O,
  output logic                          SO_OE_O,
  input  wire logic                     PAGE_SIZE_BIN_I,
  input  wire logic                     BUSY_I,
  input  wire logic                     OP_IS_MODIFY_I,
  input  wire logic                     OP_IS_PROT_MOD_I,
  input  wire logic                     OP_WP_EXEMPT_I,
  output logic                          OPCODE_VALID_O,
  output logic [OPC_BITS-1:0]           OPCODE_O,
  output logic                          ADDR_VALID_O,
  output logic [PAGE_BITS-1:0]          PAGE_SELECT_BITS_O,
  output logic [STD_BYTE_BITS-1:0]      BYTE_IN_PAGE_BITS_O,
  output logic [STD_BYTE_BITS-1:0]      BUFFER_BYTE_BITS_STD_O,
  output logic [BIN_BYTE_BITS-1:0]      BUFFER_BYTE_BITS_BINARY_O,
  output logic [BIN_LIN_BITS-1:0]       LINEAR_ARRAY_BITS_O,
  output logic                          DATA_VALID_O,
  output logic [7:0]                    DATA_BYTE_O,
  output logic                          TX_LOAD_O,
  input  wire logic [7:0]               TX_DATA_I,
  output logic                          CMD_END_O,
  output logic                          REJECT_O,
  output logic                          STANDBY_O,
  output logic                          WP_ACTIVE_O,
  output logic                          ABORT_O
);

  logic [4:0]     pins_s;
  logic           cs_n_s;
  logic           sck_s;
  logic           si_s;
  logic           wp_n_s;
  logic           reset_n_s;
  logic           por_rst;
  logic           int_rst;
  logic           sck_q;
  logic           cs_q;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_fall;
  logic           cs_rise;
  sfcfe_state_t   state;
  sfcfe_state_t   next_state;
  sfcfe_state_t   end_state;
  logic [4:0]     bit_cnt;
  logic [ADDR_BITS-1:0] in_shift;
  logic           shifting;
  logic           opc_done;
  logic           addr_done;
  logic           byte_done;
  logic           reject;
  logic [7:0]     out_sr;
  logic [2:0]     out_cnt;

  // sync reset values hold wp_n and reset_n deasserted only while RST_I is high
  sfcfe_sync #(.W(5), .RST_VAL(PIN_RST_VAL)) u_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   ({CS_N_I, SCK_I, SI_I, WP_N_I, RESET_N_I}),
    .q_o   (pins_s)
  );

  sfcfe_por #(.CYC(POR_CYC)) u_por (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .por_o (por_rst)
  );

  assign cs_n_s    = pins_s[4];
  assign sck_s     = pins_s[3];
  assign si_s      = pins_s[2];
  assign wp_n_s    = pins_s[1];
  assign reset_n_s = pins_s[0];

  assign int_rst = por_rst | ~reset_n_s;

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end
    else
    begin
      sck_q <= sck_s;
      cs_q  <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_q;
  assign sck_fall = ~sck_s & sck_q;
  assign cs_fall  = ~cs_n_s & cs_q;
  assign cs_rise  = cs_n_s & ~cs_q;

  assign shifting  = (state == ST_OPC) | (state == ST_ADDR)
                   | (state == ST_DATA);
  assign opc_done  = (state == ST_OPC) & (bit_cnt == OPC_CNT);
  assign addr_done = (state == ST_ADDR) & (bit_cnt == ADDR_CNT);
  assign byte_done = (state == ST_DATA) & (bit_cnt == BYTE_CNT);

  // exempt commands win over the write-protect block
  assign reject = ~wp_n_s & ~OP_WP_EXEMPT_I
                & (OP_IS_MODIFY_I | OP_IS_PROT_MOD_I);

  assign end_state = BUSY_I ? ST_HOLD : ST_IDLE;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cs_fall)
          next_state = ST_OPC;
      ST_OPC:
        if (cs_rise)
          next_state = end_state;
        else if (opc_done)
          next_state = reject ? ST_REJ : ST_ADDR;
      ST_ADDR:
        if (cs_rise)
          next_state = end_state;
        else if (addr_done)
          next_state = ST_DATA;
      ST_DATA:
        if (cs_rise)
          next_state = end_state;
      ST_REJ:
        if (cs_rise)
          next_state = end_state;
      ST_HOLD:
        if (cs_fall)
          next_state = ST_OPC;
        else if (!BUSY_I)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (int_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (int_rst || cs_fall || opc_done || addr_done || byte_done)
      bit_cnt <= '0;
    else if (sck_rise && !cs_n_s && shifting)
      bit_cnt <= bit_cnt + 1'b1;
  end

  // msb first: new bit enters at the bottom
  always_ff @(posedge MCLK_I)
  begin
    if (int_rst)
      in_shift <= '0;
    else if (sck_rise && !cs_n_s && shifting)
      in_shift <= {in_shift[ADDR_BITS-2:0], si_s};
  end

  assign OPCODE_VALID_O = opc_done;
  assign OPCODE_O       = in_shift[OPC_BITS-1:0];

  // upper bits beyond the field are dummies and are dropped
  always_ff @(posedge MCLK_I)
  begin
    if (int_rst)
    begin
      ADDR_VALID_O              <= 1'b0;
      PAGE_SELECT_BITS_O        <= '0;
      BYTE_IN_PAGE_BITS_O       <= '0;
      BUFFER_BYTE_BITS_STD_O    <= '0;
      BUFFER_BYTE_BITS_BINARY_O <= '0;
      LINEAR_ARRAY_BITS_O       <= '0;
    end
    else
    begin
      ADDR_VALID_O <= addr_done;
      if (addr_done)
      begin
        BUFFER_BYTE_BITS_STD_O    <= in_shift[STD_BYTE_BITS-1:0];
        BUFFER_BYTE_BITS_BINARY_O <= in_shift[BIN_BYTE_BITS-1:0];
        LINEAR_ARRAY_BITS_O       <= in_shift[BIN_LIN_BITS-1:0];
        if (PAGE_SIZE_BIN_I)
        begin
          PAGE_SELECT_BITS_O  <= in_shift[BIN_PAGE_LSB +: PAGE_BITS];
          BYTE_IN_PAGE_BITS_O <= {1'b0, in_shift[BIN_BYTE_BITS-1:0]};
        end
        else
        begin
          PAGE_SELECT_BITS_O  <= in_shift[STD_PAGE_LSB +: PAGE_BITS];
          BYTE_IN_PAGE_BITS_O <= in_shift[STD_BYTE_BITS-1:0];
        end
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (int_rst)
    begin
      DATA_VALID_O <= 1'b0;
      DATA_BYTE_O  <= '0;
    end
    else
    begin
      DATA_VALID_O <= byte_done;
      if (byte_done)
        DATA_BYTE_O <= in_shift[7:0];
    end
  end

  // only an accepted command deselected in the address or data phase reaches the array
  always_ff @(posedge MCLK_I)
  begin
    if (int_rst)
      CMD_END_O <= 1'b0;
    else
      CMD_END_O <= cs_rise & ((state == ST_ADDR) | (state == ST_DATA));
  end

  assign TX_LOAD_O = (state == ST_DATA) & sck_fall & ~cs_n_s
                   & (out_cnt == '0);

  always_ff @(posedge MCLK_I)
  begin
    if (int_rst || cs_fall)
    begin
      SO_O    <= 1'b0;
      out_sr  <= '0;
      out_cnt <= '0;
    end
    else if (TX_LOAD_O)
    begin
      SO_O    <= TX_DATA_I[7];
      out_sr  <= {TX_DATA_I[6:0], 1'b0};
      out_cnt <= OUT_LAST;
    end
    else if (sck_fall && !cs_n_s && state == ST_DATA)
    begin
      SO_O    <= out_sr[7];
      out_sr  <= {out_sr[6:0], 1'b0};
      out_cnt <= out_cnt - 1'b1;
    end
  end

  // enable follows the synchronised select, two clocks late
  assign SO_OE_O     = ~cs_n_s;
  assign REJECT_O    = (state == ST_REJ);
  assign STANDBY_O   = (state == ST_IDLE);
  assign WP_ACTIVE_O = ~wp_n_s;
  assign ABORT_O     = ~reset_n_s;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence seq_opc_blocked;
    opc_done && reject && !cs_rise;
  endsequence

  sequence seq_rej_close;
    (state == ST_REJ) && cs_rise && !BUSY_I;
  endsequence

  so_tristate_a: assert property (CS_N_I |-> ##2 !SO_OE_O)
    else $error("serial output driven while deselected");
  blocked_no_addr_a: assert property (
    seq_opc_blocked |=> (state == ST_REJ) ##1 !ADDR_VALID_O)
    else $error("protected command was not discarded");
  reject_idle_a: assert property (seq_rej_close |=> STANDBY_O)
    else $error("rejected command did not return to idle");
  exempt_accept_a: assert property (
    opc_done && OP_WP_EXEMPT_I && !cs_rise |=> state == ST_ADDR)
    else $error("exempt command refused under write protect");
  pin_reset_a: assert property (
    !reset_n_s ##1 !reset_n_s |-> STANDBY_O && !ADDR_VALID_O)
    else $error("core not held idle under reset pin");
  sample_rise_a: assert property (disable iff (int_rst)
    !(sck_rise && !cs_n_s && shifting) |=> $stable(in_shift))
    else $error("input shifted without a serial clock rise");
  desel_ignore_a: assert property (disable iff (int_rst)
    cs_n_s && !int_rst |=> $stable(in_shift) && $stable(bit_cnt))
    else $error("input accepted while deselected");
  out_fall_a: assert property (disable iff (int_rst)
    $changed(SO_O) && !$past(cs_fall) |-> $past(sck_fall))
    else $error("serial output changed off a clock fall");
  busy_hold_a: assert property (
    shifting && cs_rise && BUSY_I |=> !STANDBY_O [*2])
    else $error("standby entered while still busy");
  std_page_a: assert property (
    addr_done && !PAGE_SIZE_BIN_I |=>
      {PAGE_SELECT_BITS_O, BYTE_IN_PAGE_BITS_O} == $past(in_shift[21:0]))
    else $error("standard page address decoded wrongly");
  bin_page_a: assert property (
    addr_done && PAGE_SIZE_BIN_I |=>
      {PAGE_SELECT_BITS_O, BYTE_IN_PAGE_BITS_O[8:0]} == LINEAR_ARRAY_BITS_O)
    else $error("binary page address decoded wrongly");

endmodule
`default_nettype wire

// File: dv/sfcfe_host.sv
// host model: frames commands on select, clock and serial input
// assumes the device answers on so_i; sck rests low between frames
`timescale 1ns/10ps
`default_nettype none
module sfcfe_host (
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  localparam int HALF_NS = 400;
  initial
  begin
    cs_n_o = 1'h1;
    sck_o  = 1'h0;
    si_o   = 1'h0;
  end
  task automatic start();
    cs_n_o = 1'h0;
    #(HALF_NS);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si_o = tx[i];
      #(HALF_NS);
      sck_o = 1'h1;
      #(HALF_NS / 2);
      rx[i] = so_i;
      #(HALF_NS / 2);
      sck_o = 1'h0;
    end
  endtask
  // dummies on top, address right-aligned by the caller
  task automatic send_addr(input logic [23:0] a);
    logic [7:0] rx;
    xfer(a[23:16], rx);
    xfer(a[15:8], rx);
    xfer(a[7:0], rx);
  endtask
  // si not held after release: flip it so a stale bit cannot pass
  task automatic stop();
    cs_n_o = 1'h1;
    si_o = ~si_o;
    #(HALF_NS);
  endtask
  // clock activity while deselected, used on purpose only
  task automatic noise(input int n);
    repeat (n)
    begin
      si_o = ~si_o;
      #(HALF_NS) sck_o = 1'h1;
      #(HALF_NS) sck_o = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/sfcfe_top_test.sv
// bench for the command front end: framing, fields, protect, reset
// assumes the host model drives the link pins
`timescale 1ns/10ps
`default_nettype none
module sfcfe_top_test;
  localparam logic [7:0]  OP_MOD = 8'h82;
  localparam logic [7:0]  OP_PRT = 8'hFC;
  localparam logic [7:0]  OP_EXM = 8'h3D;
  localparam logic [7:0]  OP_RD  = 8'h0B;
  localparam logic [7:0]  WDATA  = 8'h5A;
  localparam logic [23:0] ADDR   = 24'hA5C37E;
  logic        mclk, rst, wp_n, rst_n, pg_bin, busy, cs_n, sck, si;
  logic        so, so_oe, op_v, ad_v, dv, ce, rej, stby, wpa, abt, txl;
  logic [7:0]  opc, db, txb, op_seen, data_seen;
  logic [11:0] pg;
  logic [9:0]  bip, bstd;
  logic [8:0]  bbin;
  logic [20:0] lin;
  logic        saw_rej;
  int          n_addr, n_data, n_end, n_load, err_total, tests_run;
  sfcfe_host host_u (.so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  sfcfe_top #(.POR_CYC(2)) dut_u (
    .MCLK_I(mclk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si),
    .WP_N_I(wp_n), .RESET_N_I(rst_n), .SO_O(so), .SO_OE_O(so_oe),
    .PAGE_SIZE_BIN_I(pg_bin), .BUSY_I(busy),
    .OP_IS_MODIFY_I(opc == OP_MOD),
    .OP_IS_PROT_MOD_I(opc == OP_PRT || opc == OP_EXM),
    .OP_WP_EXEMPT_I(opc == OP_EXM), .OPCODE_VALID_O(op_v),
    .OPCODE_O(opc), .ADDR_VALID_O(ad_v), .PAGE_SELECT_BITS_O(pg),
    .BYTE_IN_PAGE_BITS_O(bip), .BUFFER_BYTE_BITS_STD_O(bstd),
    .BUFFER_BYTE_BITS_BINARY_O(bbin), .LINEAR_ARRAY_BITS_O(lin),
    .DATA_VALID_O(dv), .DATA_BYTE_O(db), .TX_LOAD_O(txl), .TX_DATA_I(txb),
    .CMD_END_O(ce), .REJECT_O(rej), .STANDBY_O(stby),
    .WP_ACTIVE_O(wpa), .ABORT_O(abt));
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // pulses last one cycle, so they are tallied here
  always @(posedge mclk)
  begin
    if (op_v === 1'h1) op_seen <= opc;
    if (ad_v === 1'h1) n_addr <= n_addr + 1;
    if (dv === 1'h1) n_data <= n_data + 1;
    if (dv === 1'h1) data_seen <= db;
    if (ce === 1'h1) n_end <= n_end + 1;
    if (txl === 1'h1) n_load <= n_load + 1;
    if (rej === 1'h1) saw_rej <= 1'h1;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (stby !== 1'h1 && n < 60)
    begin
      @(negedge mclk);
      n++;
    end
    chk(stby, 1'h1, "no standby");
    if (stby !== 1'h1) give_verdict();
  endtask
  task automatic frame(input logic [7:0] op, input logic ok,
                       input logic idle);
    logic [7:0] rx;
    @(negedge mclk);
    n_addr = 0;
    n_data = 0;
    n_end = 0;
    n_load = 0;
    saw_rej = 1'h0;
    host_u.start();
    host_u.xfer(op, rx);
    host_u.send_addr(ADDR);
    host_u.xfer(WDATA, rx);
    chk(so_oe, 1'h1, "output not driven");
    host_u.stop();
    if (idle) wait_idle();
    if (ok)
    begin
      chk(rx, txb, "read byte");
      chk(op_seen, op, "opcode");
      chk(data_seen, WDATA, "write byte");
      chk(n_addr, 32'h1, "address count");
      chk(n_data, 32'h1, "data count");
      chk(n_load, 32'h1, "load count");
      if (idle) chk(n_end, 32'h1, "end count");
    end
    else
    begin
      chk(saw_rej, 1'h1, "no reject");
      chk(n_addr + n_data + n_end + n_load, 32'h0, "rejected went on");
    end
    if (idle) chk(so_oe, 1'h0, "output driven idle");
  endtask
  task automatic t_plain();
    host_u.noise(5);
    chk(n_data, 32'h0, "deselected bits");
    frame(OP_MOD, 1'h1, 1'h1);
    chk(pg, ADDR[21:10], "std page");
    chk(bip, ADDR[9:0], "std byte");
    chk(bstd, ADDR[9:0], "std buffer");
    $display("test plain done");
  endtask
  task automatic t_binary();
    pg_bin = 1'h1;
    frame(OP_RD, 1'h1, 1'h1);
    chk(lin, ADDR[20:0], "linear");
    chk(pg, ADDR[20:9], "bin page");
    chk(bip, {1'h0, ADDR[8:0]}, "bin byte");
    chk(bbin, ADDR[8:0], "bin buffer");
    pg_bin = 1'h0;
    $display("test binary done");
  endtask
  task automatic t_protect();
    wp_n = 1'h0;
    repeat (5) @(negedge mclk);
    chk(wpa, 1'h1, "protect level");
    frame(OP_MOD, 1'h0, 1'h1);
    frame(OP_PRT, 1'h0, 1'h1);
    frame(OP_EXM, 1'h1, 1'h1);
    wp_n = 1'h1;
    repeat (5) @(negedge mclk);
    chk(wpa, 1'h0, "protect release");
    $display("test protect done");
  endtask
  task automatic t_busy();
    busy = 1'h1;
    frame(OP_MOD, 1'h1, 1'h0);
    repeat (10) @(negedge mclk);
    chk(stby, 1'h0, "standby while busy");
    frame(OP_RD, 1'h1, 1'h0);
    busy = 1'h0;
    wait_idle();
    $display("test busy done");
  endtask
  task automatic t_pin_reset();
    logic [7:0] rx;
    @(negedge mclk);
    host_u.start();
    host_u.xfer(OP_MOD, rx);
    rst_n = 1'h0;
    repeat (6) @(negedge mclk);
    chk(abt, 1'h1, "abort level");
    chk(stby, 1'h1, "idle in reset");
    host_u.xfer(ADDR[23:16], rx);
    chk(stby, 1'h1, "held in reset");
    rst_n = 1'h1;
    host_u.stop();
    wait_idle();
    chk(abt, 1'h0, "abort release");
    frame(OP_RD, 1'h1, 1'h1);
    $display("test pin reset done");
  endtask
  initial
  begin
    rst = 1'h1;
    wp_n = 1'h1;
    rst_n = 1'h1;
    pg_bin = 1'h0;
    busy = 1'h0;
    txb = 8'h96;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(negedge mclk);
    rst = 1'h0;
    repeat (10) @(negedge mclk);
    chk(stby, 1'h1, "idle after power-on");
    t_plain();
    t_binary();
    t_protect();
    t_busy();
    t_pin_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
